// File: core/lpg_regs.vh
// register map, field layout and reset values of the low-side gating block
// How it works
// - Drive permit low forces gates off unless bypassed
// - Either supply undervoltage forces every gate off
// - Missing clock forces off when shutoff bit set
// - Gate on only when every condition permits
// - Channel six alone among general channels bypasses
// - DC/DC bypass ignores drive permit, not others
// - Gate pin high on command, low otherwise
// - Channels one to six hold two-bit slew codes
// - Channels one to six hold four-bit threshold codes
// - Channels seven, eight hold rise and fall codes
// - Edge codes select 1500, 300, 50, 25 V/us
// - DC/DC channels pass PWM up to full duty
// - DC/DC channels work as ordinary gated channels
`ifndef LPG_REGS_VH
`define LPG_REGS_VH

// ****************************************
// register addresses
// ****************************************
`define LPG_ADDR_W 9
`define LPG_DATA_W 16
`define LPG_OFS_THR_ONE 9'h16f
`define LPG_OFS_THR_TWO 9'h170
`define LPG_OFS_EDGE_TWO 9'h173
`define LPG_OFS_CLK_STATE 9'h1a8
`define LPG_OFS_OUT_A 9'h1c2
`define LPG_OFS_OUT_B 9'h1c5
`define LPG_OFS_OUT_C 9'h1c8
`define LPG_OFS_OUT_D 9'h1cb
`define LPG_OFS_OUT_E 9'h1ce
`define LPG_OFS_OUT_F 9'h1d1
`define LPG_OFS_DCDC_A 9'h1d4
`define LPG_OFS_DCDC_B 9'h1d7

// ****************************************
// field positions
// ****************************************
`define LPG_OUT_SLEW_LSB 0
`define LPG_OUT_BYPASS_BIT 2
`define LPG_OUT_CMD_BIT 15
`define LPG_DCDC_BYPASS_BIT 0
`define LPG_CLK_SHUTOFF_BIT 0
`define LPG_CLK_LOCK_BIT 1
`define LPG_CLK_TRIPPED_BIT 2

// ****************************************
// reset values
// ****************************************
`define LPG_RST_SLEW 2'h0
`define LPG_RST_THR 4'h0
`define LPG_RST_EDGE 2'h0
`define LPG_RST_BYPASS 1'h0
`define LPG_RST_SHUTOFF 1'h0

`endif

// File: core/lpg_gate_cell.v
// one low-side channel: gate command built from request and permits
`timescale 1ns/1ns
`default_nettype none

module lpg_gate_cell #(
	parameter HAS_BYPASS = 1'b0
) (
	// clock and reset
	input wire core_clk,
	input wire nrst,
	// command inputs
	input wire gate_request,
	input wire global_drive_permit,
	input wire permit_bypass,
	input wire predriver_supply_low,
	input wire logic_supply_low,
	input wire clock_ok_permit,
	// gate pin drive
	output reg gate_drive_q
);

	wire bypass_ok;
	wire gate_drive_d;

	// only channels built with a bypass may skip the drive permit
	assign bypass_ok = HAS_BYPASS & permit_bypass;

	// every off condition wins; no minimum off time so full duty passes
	assign gate_drive_d = gate_request
		& ~predriver_supply_low & ~logic_supply_low
		& clock_ok_permit
		& (global_drive_permit | bypass_ok);

	// registered pin drive: high pulls gate to supply, low to power_ground
	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			gate_drive_q <= 1'b0;
		end else begin
			gate_drive_q <= gate_drive_d;
		end
	end

endmodule // lpg_gate_cell

`default_nettype wire

// File: core/lpg_gating.v
// top of the low-side pre-driver gating block with its register file
`timescale 1ns/1ns
`default_nettype none
`include "lpg_regs.vh"

module lpg_gating #(
	parameter NUM_GP = 6,
	parameter NUM_DCDC = 2
) (
	// clock and reset
	input wire core_clk,
	input wire nrst,
	// asynchronous level inputs from analog monitors and pins
	input wire global_drive_permit,
	input wire predriver_supply_low,
	input wire logic_supply_low,
	input wire pll_locked,
	// channel logic requests, same clock
	input wire [NUM_GP-1:0] gp_gate_request,
	input wire [NUM_DCDC-1:0] dcdc_gate_request,
	// register port from the serial interface core
	input wire [`LPG_ADDR_W-1:0] reg_addr,
	input wire reg_wr_en,
	input wire [`LPG_DATA_W-1:0] reg_wdata,
	input wire reg_rd_en,
	output reg [`LPG_DATA_W-1:0] reg_rdata_q,
	output reg reg_rvalid_q,
	// gate pin drives
	output wire [NUM_GP+NUM_DCDC-1:0] gate_drive,
	// analog configuration, channels one to six
	output wire [2*NUM_GP-1:0] gp_slew_code,
	output wire [4*NUM_GP-1:0] gp_drain_threshold,
	// analog configuration, channels seven and eight
	output wire [2*NUM_DCDC-1:0] dcdc_turn_on_strength,
	output wire [2*NUM_DCDC-1:0] dcdc_turn_off_strength
);

	// ****************************************
	// input synchronisers
	// ****************************************

	localparam NUM_SYNC = 4;
	localparam SYNC_PERMIT = 0;
	localparam SYNC_PRED = 1;
	localparam SYNC_LOGIC = 2;
	localparam SYNC_LOCK = 3;
	// safe levels while in reset: no permit, supplies low, clock lost
	// so no gate can rise before the monitors have really been sampled
	localparam [NUM_SYNC-1:0] SYNC_RST = 4'h6;

	wire [NUM_SYNC-1:0] sync_in;
	reg [NUM_SYNC-1:0] sync1_q;
	reg [NUM_SYNC-1:0] sync2_q;
	reg [NUM_SYNC-1:0] sync3_q;
	reg [NUM_SYNC-1:0] level_q;
	wire [NUM_SYNC-1:0] level_d;

	assign sync_in = {pll_locked, logic_supply_low, predriver_supply_low,
		global_drive_permit};

	// three stages; first stage feeds only the second
	// stage one may go metastable, so nothing else may read it
	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			sync1_q <= SYNC_RST;
			sync2_q <= SYNC_RST;
			sync3_q <= SYNC_RST;
		end else begin
			sync1_q <= sync_in;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
		end
	end

	// a change is accepted once stages two and three agree
	genvar gs;
	generate
		for (gs = 0; gs < NUM_SYNC; gs = gs + 1) begin : g_filt
			assign level_d[gs] = (sync2_q[gs] == sync3_q[gs]) ? sync3_q[gs] : level_q[gs];
		end
	endgenerate

	// filtered levels; costs three to four cycles of latency, far below any
	// gate edge time, and rejects single-cycle glitches from the monitors
	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			level_q <= SYNC_RST;
		end else begin
			level_q <= level_d;
		end
	end

	wire permit_s;
	wire pred_low_s;
	wire logic_low_s;
	wire lock_s;

	assign permit_s = level_q[SYNC_PERMIT];
	assign pred_low_s = level_q[SYNC_PRED];
	assign logic_low_s = level_q[SYNC_LOGIC];
	assign lock_s = level_q[SYNC_LOCK];

	// ****************************************
	// configuration registers
	// ****************************************

	reg [2*NUM_GP-1:0] slew_q;
	reg [4*NUM_GP-1:0] thr_q;
	reg [2*NUM_DCDC-1:0] rise_q;
	reg [2*NUM_DCDC-1:0] fall_q;
	reg ch6_permit_bypass_q;
	reg [NUM_DCDC-1:0] dcdc_permit_bypass_q;
	reg clk_shutoff_en_q;

	// write strobes per register
	// full-address compare: unmapped writes fall through and change nothing
	// read-only fields have no storage, so writes to them are dropped
	wire wr_thr_one;
	wire wr_thr_two;
	wire wr_edge_two;
	wire wr_clk_state;
	wire [NUM_GP-1:0] wr_out;
	wire [NUM_DCDC-1:0] wr_dcdc;

	assign wr_thr_one = reg_wr_en & (reg_addr == `LPG_OFS_THR_ONE);
	assign wr_thr_two = reg_wr_en & (reg_addr == `LPG_OFS_THR_TWO);
	assign wr_edge_two = reg_wr_en & (reg_addr == `LPG_OFS_EDGE_TWO);
	assign wr_clk_state = reg_wr_en & (reg_addr == `LPG_OFS_CLK_STATE);
	assign wr_out[0] = reg_wr_en & (reg_addr == `LPG_OFS_OUT_A);
	assign wr_out[1] = reg_wr_en & (reg_addr == `LPG_OFS_OUT_B);
	assign wr_out[2] = reg_wr_en & (reg_addr == `LPG_OFS_OUT_C);
	assign wr_out[3] = reg_wr_en & (reg_addr == `LPG_OFS_OUT_D);
	assign wr_out[4] = reg_wr_en & (reg_addr == `LPG_OFS_OUT_E);
	assign wr_out[5] = reg_wr_en & (reg_addr == `LPG_OFS_OUT_F);
	assign wr_dcdc[0] = reg_wr_en & (reg_addr == `LPG_OFS_DCDC_A);
	assign wr_dcdc[1] = reg_wr_en & (reg_addr == `LPG_OFS_DCDC_B);

	// drain thresholds: part one holds channels 1..4, part two channels 5..6
	// upper byte of part two is unused and reads back as zero
	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			thr_q <= {NUM_GP{`LPG_RST_THR}};
		end else begin
			if (wr_thr_one) begin
				thr_q[15:0] <= reg_wdata;
			end
			if (wr_thr_two) begin
				thr_q[23:16] <= reg_wdata[7:0];
			end
		end
	end

	// dcdc edge strengths: per channel rise in [1:0], fall in [3:2]
	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			rise_q <= {NUM_DCDC{`LPG_RST_EDGE}};
			fall_q <= {NUM_DCDC{`LPG_RST_EDGE}};
		end else if (wr_edge_two) begin
			rise_q[1:0] <= reg_wdata[1:0];
			fall_q[1:0] <= reg_wdata[3:2];
			rise_q[3:2] <= reg_wdata[5:4];
			fall_q[3:2] <= reg_wdata[7:6];
		end
	end

	// clock-loss shutoff enable, off after reset
	// trade-off: armed only by software, so a cold start never trips on the pll
	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			clk_shutoff_en_q <= `LPG_RST_SHUTOFF;
		end else if (wr_clk_state) begin
			clk_shutoff_en_q <= reg_wdata[`LPG_CLK_SHUTOFF_BIT];
		end
	end

	// general channel slew codes; bypass bit is kept only for channel six
	genvar gc;
	generate
		for (gc = 0; gc < NUM_GP; gc = gc + 1) begin : g_slew
			always @(posedge core_clk or negedge nrst) begin
				if (!nrst) begin
					slew_q[2*gc+1:2*gc] <= `LPG_RST_SLEW;
				end else if (wr_out[gc]) begin
					slew_q[2*gc+1:2*gc] <= reg_wdata[`LPG_OUT_SLEW_LSB+1:`LPG_OUT_SLEW_LSB];
				end
			end
		end
	endgenerate

	// channel six bypass: the other general channels have no such storage
	// keeping bypass storage out of channels 1..5 means no write can defeat
	// their drive permit path
	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			ch6_permit_bypass_q <= `LPG_RST_BYPASS;
		end else if (wr_out[NUM_GP-1]) begin
			ch6_permit_bypass_q <= reg_wdata[`LPG_OUT_BYPASS_BIT];
		end
	end

	// dcdc channel bypass bits
	genvar gd;
	generate
		for (gd = 0; gd < NUM_DCDC; gd = gd + 1) begin : g_dcdc_cfg
			always @(posedge core_clk or negedge nrst) begin
				if (!nrst) begin
					dcdc_permit_bypass_q[gd] <= `LPG_RST_BYPASS;
				end else if (wr_dcdc[gd]) begin
					dcdc_permit_bypass_q[gd] <= reg_wdata[`LPG_DCDC_BYPASS_BIT];
				end
			end
		end
	endgenerate

	// ****************************************
	// gating
	// ****************************************

	wire clock_ok_permit;
	wire [NUM_GP+NUM_DCDC-1:0] all_request;
	wire [NUM_GP+NUM_DCDC-1:0] all_bypass;

	// lost clock only matters once software has armed the shutoff
	// the lock level is the filtered one, so a one-cycle lock glitch is ignored
	assign clock_ok_permit = ~(clk_shutoff_en_q & ~lock_s);

	assign all_request = {dcdc_gate_request, gp_gate_request};
	assign all_bypass = {dcdc_permit_bypass_q, ch6_permit_bypass_q, {(NUM_GP-1){1'b0}}};

	// channels 1..5 without bypass, channel 6 and dcdc channels with it;
	// dcdc channels share the same cell, so they serve as plain channels too
	genvar gg;
	generate
		for (gg = 0; gg < NUM_GP + NUM_DCDC; gg = gg + 1) begin : g_gate
			lpg_gate_cell #(
				.HAS_BYPASS((gg >= NUM_GP - 1) ? 1'b1 : 1'b0)
			) u_cell (
				.core_clk(core_clk),
				.nrst(nrst),
				.gate_request(all_request[gg]),
				.global_drive_permit(permit_s),
				.permit_bypass(all_bypass[gg]),
				.predriver_supply_low(pred_low_s),
				.logic_supply_low(logic_low_s),
				.clock_ok_permit(clock_ok_permit),
				.gate_drive_q(gate_drive[gg])
			);
		end
	endgenerate

	// ****************************************
	// analog configuration outputs
	// ****************************************

	// codes go straight from their registers to the drivers and comparators
	// limitation: a code change during a gate edge applies at once, no retiming
	assign gp_slew_code = slew_q;
	assign gp_drain_threshold = thr_q;
	assign dcdc_turn_on_strength = rise_q;
	assign dcdc_turn_off_strength = fall_q;

	// ****************************************
	// register read back
	// ****************************************

	reg [`LPG_DATA_W-1:0] rd_mux;

	// out_cfg words also show the channel's live gate command in bit 15
	// purely combinational on reg_addr; only the read strobe samples it
	always @* begin
		rd_mux = {`LPG_DATA_W{1'b0}};
		case (reg_addr)
			`LPG_OFS_THR_ONE: begin
				rd_mux = thr_q[15:0];
			end
			`LPG_OFS_THR_TWO: begin
				rd_mux[7:0] = thr_q[23:16];
			end
			`LPG_OFS_EDGE_TWO: begin
				rd_mux[7:0] = {fall_q[3:2], rise_q[3:2], fall_q[1:0], rise_q[1:0]};
			end
			`LPG_OFS_CLK_STATE: begin
				rd_mux[`LPG_CLK_SHUTOFF_BIT] = clk_shutoff_en_q;
				rd_mux[`LPG_CLK_LOCK_BIT] = lock_s;
				rd_mux[`LPG_CLK_TRIPPED_BIT] = ~clock_ok_permit;
			end
			`LPG_OFS_OUT_A: begin
				rd_mux[1:0] = slew_q[1:0];
				rd_mux[`LPG_OUT_CMD_BIT] = gate_drive[0];
			end
			`LPG_OFS_OUT_B: begin
				rd_mux[1:0] = slew_q[3:2];
				rd_mux[`LPG_OUT_CMD_BIT] = gate_drive[1];
			end
			`LPG_OFS_OUT_C: begin
				rd_mux[1:0] = slew_q[5:4];
				rd_mux[`LPG_OUT_CMD_BIT] = gate_drive[2];
			end
			`LPG_OFS_OUT_D: begin
				rd_mux[1:0] = slew_q[7:6];
				rd_mux[`LPG_OUT_CMD_BIT] = gate_drive[3];
			end
			`LPG_OFS_OUT_E: begin
				rd_mux[1:0] = slew_q[9:8];
				rd_mux[`LPG_OUT_CMD_BIT] = gate_drive[4];
			end
			`LPG_OFS_OUT_F: begin
				rd_mux[1:0] = slew_q[11:10];
				rd_mux[`LPG_OUT_BYPASS_BIT] = ch6_permit_bypass_q;
				rd_mux[`LPG_OUT_CMD_BIT] = gate_drive[5];
			end
			`LPG_OFS_DCDC_A: begin
				rd_mux[`LPG_DCDC_BYPASS_BIT] = dcdc_permit_bypass_q[0];
				rd_mux[`LPG_OUT_CMD_BIT] = gate_drive[6];
			end
			`LPG_OFS_DCDC_B: begin
				rd_mux[`LPG_DCDC_BYPASS_BIT] = dcdc_permit_bypass_q[1];
				rd_mux[`LPG_OUT_CMD_BIT] = gate_drive[7];
			end
			default: begin
				rd_mux = {`LPG_DATA_W{1'b0}}; // unmapped reads as zero
			end
		endcase
	end

	// read data held in a register so the serial shifter sees a stable word
	// rvalid is a pulse; rdata keeps the last word until the next read
	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			reg_rdata_q <= {`LPG_DATA_W{1'b0}};
			reg_rvalid_q <= 1'b0;
		end else begin
			reg_rvalid_q <= reg_rd_en;
			if (reg_rd_en) begin
				reg_rdata_q <= rd_mux;
			end
		end
	end

endmodule // lpg_gating

`default_nettype wire

// File: verif/lpg_mosfet_model.sv
// external power switch gates seen from the gate pins
`timescale 1ns/1ns
`default_nettype none
module lpg_mosfet_model #(
	parameter N = 8
) (
	// pins and reset
	input wire logic nrst,
	input wire logic [N-1:0] gate_drive,
	// switch state
	output wire logic [N-1:0] mosfet_on
);
	// pull-down keeps switches off while reset holds the pins
	assign mosfet_on = nrst ? gate_drive : '0;
endmodule // lpg_mosfet_model
`default_nettype wire

// File: verif/lpg_gating_assertions.sv
// port checks for the low-side gating block
`timescale 1ns/1ns
`default_nettype none
`include "lpg_regs.vh"
module lpg_gating_assertions #(
	parameter NUM_GP = 6,
	parameter NUM_DCDC = 2
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic nrst,
	// levels and requests
	input wire logic global_drive_permit,
	input wire logic predriver_supply_low,
	input wire logic logic_supply_low,
	input wire logic pll_locked,
	input wire logic [NUM_GP-1:0] gp_gate_request,
	input wire logic [NUM_DCDC-1:0] dcdc_gate_request,
	// register port
	input wire logic [`LPG_ADDR_W-1:0] reg_addr,
	input wire logic reg_wr_en,
	input wire logic [`LPG_DATA_W-1:0] reg_wdata,
	input wire logic reg_rd_en,
	input wire logic [`LPG_DATA_W-1:0] reg_rdata_q,
	input wire logic reg_rvalid_q,
	// outputs
	input wire logic [NUM_GP+NUM_DCDC-1:0] gate_drive,
	input wire logic [2*NUM_GP-1:0] gp_slew_code,
	input wire logic [4*NUM_GP-1:0] gp_drain_threshold,
	input wire logic [2*NUM_DCDC-1:0] dcdc_turn_on_strength,
	input wire logic [2*NUM_DCDC-1:0] dcdc_turn_off_strength
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	// async levels need four edges through sync and filter, a fifth for the gate flop
	sequence s_pred_low; predriver_supply_low [*6]; endsequence
	sequence s_logic_low; logic_supply_low [*6]; endsequence
	sequence s_permit_low; !global_drive_permit [*6]; endsequence
	sequence s_thr_wr; reg_wr_en && reg_addr == `LPG_OFS_THR_ONE; endsequence
	sequence s_edge_wr; reg_wr_en && reg_addr == `LPG_OFS_EDGE_TWO; endsequence
	a_gate_needs_request: assert property (
		(gate_drive & ~$past({dcdc_gate_request, gp_gate_request})) == '0)
		else $error("gate high without request");
	a_pred_low_off: assert property (s_pred_low |-> gate_drive == '0)
		else $error("gate on with predriver supply low");
	a_logic_low_off: assert property (s_logic_low |-> gate_drive == '0)
		else $error("gate on with logic supply low");
	a_permit_low_off: assert property (s_permit_low |-> gate_drive[NUM_GP-2:0] == '0)
		else $error("unbypassed gate on without permit");
	a_thr_write_lands: assert property (s_thr_wr |=> gp_drain_threshold[15:0] == $past(reg_wdata))
		else $error("threshold write not applied");
	a_edge_write_lands: assert property (s_edge_wr |=> {dcdc_turn_off_strength[1:0],
		dcdc_turn_on_strength[1:0]} == $past(reg_wdata[3:0]))
		else $error("edge strength write not applied");
	a_read_answers: assert property (reg_rd_en |=> reg_rvalid_q)
		else $error("read not answered");
	a_rvalid_has_cause: assert property (reg_rvalid_q |-> $past(reg_rd_en))
		else $error("read valid without read");
	a_reset_gates_off: assert property (disable iff (1'b0) !nrst |-> gate_drive == '0)
		else $error("gate on during reset");
endmodule // lpg_gating_assertions
bind lpg_gating lpg_gating_assertions #(.NUM_GP(NUM_GP), .NUM_DCDC(NUM_DCDC)) lpg_chk_inst (
	.core_clk(core_clk), .nrst(nrst), .global_drive_permit(global_drive_permit),
	.predriver_supply_low(predriver_supply_low), .logic_supply_low(logic_supply_low),
	.pll_locked(pll_locked), .gp_gate_request(gp_gate_request),
	.dcdc_gate_request(dcdc_gate_request), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
	.reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en), .reg_rdata_q(reg_rdata_q),
	.reg_rvalid_q(reg_rvalid_q), .gate_drive(gate_drive), .gp_slew_code(gp_slew_code),
	.gp_drain_threshold(gp_drain_threshold), .dcdc_turn_on_strength(dcdc_turn_on_strength),
	.dcdc_turn_off_strength(dcdc_turn_off_strength));
`default_nettype wire

// File: verif/lpg_gating_test.sv
// self-checking bench for the low-side gating block
`timescale 1ns/1ns
`default_nettype none
`include "lpg_regs.vh"
module lpg_gating_test;
	logic core_clk, nrst, permit, pv_low, lv_low, lock, wr_en, rd_en, rvalid, shut;
	logic [5:0] gp_req;
	logic [1:0] dc_req;
	logic [3:0] on_s, off_s;
	logic [8:0] addr;
	logic [15:0] wdata, rdata, x;
	logic [7:0] gate, mos_on;
	logic [11:0] slew;
	logic [23:0] thr;
	logic [2:0] byp;
	logic [31:0] lfsr_q;
	logic [15:0] exp_q[$];
	logic [8:0] out_a[6] = '{`LPG_OFS_OUT_A, `LPG_OFS_OUT_B, `LPG_OFS_OUT_C,
		`LPG_OFS_OUT_D, `LPG_OFS_OUT_E, `LPG_OFS_OUT_F};
	int n_mismatch = 0, n_compared = 0, cycles = 0;

	lpg_gating lpg_gating_inst (.core_clk(core_clk), .nrst(nrst), .global_drive_permit(permit),
		.predriver_supply_low(pv_low), .logic_supply_low(lv_low), .pll_locked(lock),
		.gp_gate_request(gp_req), .dcdc_gate_request(dc_req), .reg_addr(addr),
		.reg_wr_en(wr_en), .reg_wdata(wdata), .reg_rd_en(rd_en), .reg_rdata_q(rdata),
		.reg_rvalid_q(rvalid), .gate_drive(gate), .gp_slew_code(slew),
		.gp_drain_threshold(thr), .dcdc_turn_on_strength(on_s), .dcdc_turn_off_strength(off_s));
	lpg_mosfet_model lpg_mosfet_model_inst (.nrst(nrst), .gate_drive(gate), .mosfet_on(mos_on));

	// ****
	// tasks
	// ****
	// sixteen shifts per call so successive fields are not just shifted copies
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		for (int i = 0; i < 16; i++) begin
			s = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
		end
		return s;
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// one-cycle strobes, settled before the caller looks
	task automatic wr(input logic [8:0] a, input logic [15:0] d);
		@(posedge core_clk);
		addr <= a;
		wdata <= d;
		wr_en <= 1'b1;
		@(posedge core_clk);
		wr_en <= 1'b0;
		@(negedge core_clk);
	endtask
	task automatic rd(input logic [8:0] a, input logic [15:0] e);
		@(posedge core_clk);
		addr <= a;
		rd_en <= 1'b1;
		exp_q.push_back(e);
		@(posedge core_clk);
		rd_en <= 1'b0;
		@(negedge core_clk);
	endtask
	// six edges cover sync, filter and gate flop
	task automatic gate_case(input logic [7:0] req, input logic pm, pv, lv, lk);
		logic [7:0] e;
		@(posedge core_clk);
		{dc_req, gp_req} <= req;
		{permit, pv_low, lv_low, lock} <= {pm, pv, lv, lk};
		repeat (6) @(posedge core_clk);
		@(negedge core_clk);
		e = req & {8{~pv & ~lv & ~(shut & ~lk)}} & (pm ? 8'hff : {byp, 5'h0});
		chk(mos_on, e);
	endtask
	task automatic print_verdict();
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// ****
	// clock, read monitor, hang limit
	// ****
	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end
	always @(negedge core_clk) begin
		if (rvalid === 1'b1) chk(rdata, exp_q.pop_front());
	end
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 5000) begin
			n_mismatch++;
			print_verdict();
		end
	end

	// ****
	// main sequence
	// ****
	initial begin
		{nrst, permit, pv_low, lv_low, wr_en, rd_en, shut, gp_req, dc_req} = '0;
		{lock, addr, wdata, byp} = {1'b1, 9'h0, 16'h0, 3'h0};
		lfsr_q = 32'd68216;
		repeat (2) @(posedge core_clk);
		nrst <= 1'b1;
		repeat (6) @(posedge core_clk);
		// reset values, lock seen, shutoff off, unmapped reads zero
		rd(`LPG_OFS_THR_ONE, 16'h0);
		rd(`LPG_OFS_EDGE_TWO, 16'h0);
		rd(`LPG_OFS_CLK_STATE, 16'h0002);
		rd(`LPG_OFS_DCDC_A, 16'h0);
		rd(9'h100, 16'h0);
		for (int i = 0; i < 4; i++) begin
			lfsr_q = lfsr_next(lfsr_q);
			x = lfsr_q[15:0];
			wr(`LPG_OFS_THR_ONE, x);
			chk(thr[15:0], x);
			rd(`LPG_OFS_THR_ONE, x);
			wr(`LPG_OFS_THR_TWO, x);
			chk(thr[23:16], x[7:0]);
			rd(`LPG_OFS_THR_TWO, {8'h0, x[7:0]});
			wr(`LPG_OFS_EDGE_TWO, x);
			chk({off_s, on_s}, {x[7:6], x[3:2], x[5:4], x[1:0]});
			for (int k = 0; k < 6; k++) begin
				wr(out_a[k], x ^ 16'(k));
				chk(slew[2*k+:2], x[1:0] ^ k[1:0]);
				rd(out_a[k], (x ^ 16'(k)) & (k == 5 ? 16'h7 : 16'h3));
			end
		end
		// random gating mixes with bypass and clock shutoff
		for (int i = 0; i < 24; i++) begin
			lfsr_q = lfsr_next(lfsr_q);
			{byp, shut} = lfsr_q[3:0];
			wr(`LPG_OFS_OUT_F, {13'h0, byp[0], 2'h0});
			wr(`LPG_OFS_DCDC_A, {15'h0, byp[1]});
			wr(`LPG_OFS_DCDC_B, {15'h0, byp[2]});
			wr(`LPG_OFS_CLK_STATE, {15'h0, shut});
			gate_case(lfsr_q[15:8], lfsr_q[16], &lfsr_q[18:17], &lfsr_q[20:19], |lfsr_q[22:21]);
		end
		// full duty: request held high keeps gates on
		gate_case(8'hff, 1'b1, 1'b0, 1'b0, 1'b1);
		repeat (20) @(posedge core_clk);
		@(negedge core_clk);
		chk(gate, 8'hff);
		// reset in mid-run, asserted on a rising edge, then released again
		@(posedge core_clk);
		nrst <= 1'b0;
		{byp, shut} = 4'h0;
		@(negedge core_clk);
		chk({gate, mos_on}, 16'h0);
		chk({on_s, off_s, slew}, 20'h0);
		chk(thr, 24'h0);
		@(posedge core_clk);
		nrst <= 1'b1;
		// filtered permit still at its reset level one edge after release
		@(posedge core_clk);
		@(negedge core_clk);
		chk(gate, 8'h0);
		repeat (6) @(posedge core_clk);
		rd(`LPG_OFS_OUT_F, 16'h8000);
		rd(`LPG_OFS_CLK_STATE, 16'h0002);
		print_verdict();
	end
endmodule // lpg_gating_test
`default_nettype wire
